// ==== pcv_channel.sv ====
// Behaviour
// - Edge PWM loads pair at modulo-1 step
// - Free-running counter loads at fffe to ffff
// - Center PWM loads pair at modulo-1 step
// - Center compare equal modulo gives full duty
// - Center compare modulo-1 gives near full duty
// - Zero to nonzero waits for new period
// - Nonzero to zero finishes current period first
// - Control write in debug clears modulo pair
// - Center counts up/down, down match activates
// - Control write clears compare pair state
// - Capture mode ignores compare value writes
`include "pcv_params.svh"
`timescale 1ns/10ps
`default_nettype none
module pcv_channel #(
  parameter int CNT_W = 16
) (
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [2:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       background_debug_state_in,
  output logic            channel_pwm_out,
  output logic            channel_oe_out
);

  generate
    if (CNT_W != 16) begin : g_bad_width
      $error("pcv_channel serves a 16-bit counter only");
    end
  endgenerate

  logic [7:0]          sc_r;
  logic [7:0]          chsc_r;
  logic [15:0]         mod_r;
  logic [15:0]         cv_r;
  logic [15:0]         eff_cv_r;
  logic [15:0]         cnt_r;
  pcv_pkg::pcv_dir_t   dir_r;
  logic                pwm_r;
  logic [7:0]          rdata_r;

  logic                wr_sc;
  logic                wr_cnt;
  logic                wr_cv_ok;
  logic                mod_pend;
  logic [15:0]         mod_val;
  logic                cv_pend;
  logic [15:0]         cv_val;
  logic                cv_load;
  logic                free_w;
  logic [15:0]         top_w;
  logic                tick;
  logic                cpwm_w;
  logic                pwm_mode_w;
  logic                pol_w;
  logic                active_w;
  pcv_pkg::pcv_ch_mode_t mode_w;

  assign wr_sc      = reg_wr_in && (reg_addr_in == `PCV_ADDR_SC);
  assign wr_cnt     = reg_wr_in && ((reg_addr_in == `PCV_ADDR_CNTH) ||
                                    (reg_addr_in == `PCV_ADDR_CNTL));
  assign cpwm_w     = sc_r[`PCV_SC_CPWM_BIT];
  assign mode_w     = pcv_pkg::pcv_ch_mode_t'(chsc_r[`PCV_CH_MODE_MSB:`PCV_CH_MODE_LSB]);
  assign pol_w      = chsc_r[`PCV_CH_POL_BIT];
  assign pwm_mode_w = cpwm_w || mode_w[1];
  assign free_w     = (mod_r == `PCV_FREE_LOW) || (mod_r == `PCV_FREE_TOP);
  assign top_w      = free_w ? `PCV_FREE_TOP : mod_r;
  assign tick       = (sc_r[`PCV_SC_CLKS_MSB:`PCV_SC_CLKS_LSB] != `PCV_CLKS_OFF) &&
                      !background_debug_state_in;
  assign wr_cv_ok   = cpwm_w || (mode_w != pcv_pkg::PCV_MODE_CAPTURE);

  // Modulo byte pair
  pcv_pair_buf u_mod_buf (
    .ref_clk_in  (ref_clk_in),
    .sys_rst_in  (sys_rst_in),
    .wr_hi_in    (reg_wr_in && (reg_addr_in == `PCV_ADDR_MODH)),
    .wr_lo_in    (reg_wr_in && (reg_addr_in == `PCV_ADDR_MODL)),
    .data_in     (reg_wdata_in),
    .clear_in    (wr_sc && background_debug_state_in),
    .take_in     (mod_pend),
    .value_out   (mod_val),
    .pending_out (mod_pend)
  );

  // Compare value byte pair
  pcv_pair_buf u_cv_buf (
    .ref_clk_in  (ref_clk_in),
    .sys_rst_in  (sys_rst_in),
    .wr_hi_in    (reg_wr_in && wr_cv_ok && (reg_addr_in == `PCV_ADDR_CVH)),
    .wr_lo_in    (reg_wr_in && wr_cv_ok && (reg_addr_in == `PCV_ADDR_CVL)),
    .data_in     (reg_wdata_in),
    .clear_in    (wr_sc),
    .take_in     (cv_load),
    .value_out   (cv_val),
    .pending_out (cv_pend)
  );

  // Load point for the compare value
  always_comb begin
    cv_load = 1'b0;
    if (cv_pend && tick) begin
      if (pwm_mode_w) begin
        cv_load = (dir_r == pcv_pkg::PCV_DIR_UP) &&
                  (cnt_r == top_w - `PCV_ONE);
      end else if (mode_w == pcv_pkg::PCV_MODE_COMPARE) begin
        cv_load = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sc_r <= `PCV_SC_RST;
    end else if (wr_sc) begin
      sc_r <= reg_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      chsc_r <= `PCV_CHSC_RST;
    end else if (reg_wr_in && (reg_addr_in == `PCV_ADDR_CHSC)) begin
      chsc_r <= reg_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mod_r <= `PCV_MOD_RST;
    end else if (mod_pend) begin
      mod_r <= mod_val;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cv_r <= `PCV_CV_RST;
    end else if (cv_load) begin
      cv_r <= cv_val;
    end
  end

  // Center mode duty latched at period start
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      eff_cv_r <= `PCV_CV_RST;
    end else if (!cpwm_w || (cnt_r == `PCV_FREE_LOW)) begin
      eff_cv_r <= cv_r;
    end
  end

  // Counter and direction
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r <= `PCV_CNT_RST;
      dir_r <= pcv_pkg::PCV_DIR_UP;
    end else if (wr_cnt) begin
      cnt_r <= `PCV_CNT_RST;
      dir_r <= pcv_pkg::PCV_DIR_UP;
    end else if (tick) begin
      if (cpwm_w) begin
        case (dir_r)
          pcv_pkg::PCV_DIR_UP: begin
            if (cnt_r >= top_w) begin
              dir_r <= pcv_pkg::PCV_DIR_DOWN;
              cnt_r <= cnt_r - `PCV_ONE;
            end else begin
              cnt_r <= cnt_r + `PCV_ONE;
            end
          end
          pcv_pkg::PCV_DIR_DOWN: begin
            if (cnt_r == `PCV_FREE_LOW) begin
              dir_r <= pcv_pkg::PCV_DIR_UP;
              cnt_r <= cnt_r + `PCV_ONE;
            end else begin
              cnt_r <= cnt_r - `PCV_ONE;
            end
          end
          default: begin
            dir_r <= pcv_pkg::PCV_DIR_UP;
          end
        endcase
      end else begin
        dir_r <= pcv_pkg::PCV_DIR_UP;
        cnt_r <= (cnt_r >= top_w) ? `PCV_CNT_RST : cnt_r + `PCV_ONE;
      end
    end
  end

  // Active level of the waveform
  always_comb begin
    if (cpwm_w) begin
      if (eff_cv_r == top_w) begin
        active_w = 1'b1;
      end else if (eff_cv_r == `PCV_FREE_LOW) begin
        active_w = 1'b0;
      end else if (dir_r == pcv_pkg::PCV_DIR_DOWN) begin
        active_w = (cnt_r <= eff_cv_r);
      end else begin
        active_w = (cnt_r < eff_cv_r);
      end
    end else begin
      active_w = (cnt_r < cv_r);
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pwm_r <= 1'b0;
    end else if (pwm_mode_w) begin
      pwm_r <= pol_w ? active_w : !active_w;
    end
  end

  // Register read port
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `PCV_ADDR_SC:   rdata_r <= sc_r;
        `PCV_ADDR_CNTH: rdata_r <= cnt_r[15:8];
        `PCV_ADDR_CNTL: rdata_r <= cnt_r[7:0];
        `PCV_ADDR_MODH: rdata_r <= mod_r[15:8];
        `PCV_ADDR_MODL: rdata_r <= mod_r[7:0];
        `PCV_ADDR_CHSC: rdata_r <= chsc_r;
        `PCV_ADDR_CVH:  rdata_r <= cv_r[15:8];
        `PCV_ADDR_CVL:  rdata_r <= cv_r[7:0];
        default:        rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata_out   = rdata_r;
  assign channel_pwm_out = pwm_r;
  assign channel_oe_out  = pwm_mode_w;

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence top_reach_s;
    cpwm_w && tick && !wr_cnt && (dir_r == pcv_pkg::PCV_DIR_UP) &&
      (cnt_r == top_w) && (top_w > 16'h0001);
  endsequence

  sequence cv_step_s;
    $changed(cv_r) && $past(pwm_mode_w);
  endsequence

  edge_load_point_a: assert property (
    cv_step_s and ##0 !$past(free_w) |-> $past(cnt_r) == $past(top_w) - `PCV_ONE)
    else $error("Compare value loaded off the modulo-1 step");
  free_load_point_a: assert property (
    cv_step_s and ##0 $past(free_w) |-> $past(cnt_r) == 16'hfffe)
    else $error("Free-running load off the fffe step");
  center_load_pair_a: assert property (
    $changed(cv_r) && $past(cpwm_w) |->
      $past(cv_pend) && ($past(dir_r) == pcv_pkg::PCV_DIR_UP))
    else $error("Center load without full pair or while counting down");
  full_duty_a: assert property (
    cpwm_w && (eff_cv_r == top_w) |=> channel_pwm_out == $past(pol_w))
    else $error("Compare equal to modulo not fully active");
  near_full_a: assert property (
    cpwm_w && (eff_cv_r == top_w - `PCV_ONE) && (cnt_r == `PCV_FREE_LOW) &&
      (top_w > 16'h0001) |=> channel_pwm_out == $past(pol_w))
    else $error("Compare one below modulo inactive at period start");
  hold_duty_a: assert property (
    cpwm_w && (cnt_r != `PCV_FREE_LOW) |=> eff_cv_r == $past(eff_cv_r))
    else $error("Duty changed inside a center period");
  finish_period_a: assert property (
    $changed(eff_cv_r) && $past(cpwm_w) |-> $past(cnt_r) == `PCV_FREE_LOW)
    else $error("Duty applied away from period boundary");
  debug_mod_clear_a: assert property (
    wr_sc && background_debug_state_in |=> !mod_pend)
    else $error("Modulo pair survived control write in debug");
  turn_down_a: assert property (
    top_reach_s |=> (dir_r == pcv_pkg::PCV_DIR_DOWN) ##1 (cnt_r < top_w) [*2])
    else $error("Counter did not turn at modulo");
  cv_pair_clear_a: assert property (
    wr_sc |=> !cv_pend)
    else $error("Compare pair survived control write");
  capture_ignore_a: assert property (
    !wr_cv_ok && !wr_sc |=> cv_pend == $past(cv_pend))
    else $error("Compare write accepted in capture mode");
  pair_needed_a: assert property (
    $rose(cv_pend) |-> $past(reg_wr_in) && $past(wr_cv_ok) &&
      (($past(reg_addr_in) == `PCV_ADDR_CVH) || ($past(reg_addr_in) == `PCV_ADDR_CVL)))
    else $error("Compare pair pending without a byte write");

endmodule
`default_nettype wire

// ==== pcv_pair_buf.sv ====
`timescale 1ns/10ps
`default_nettype none
module pcv_pair_buf (
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        wr_hi_in,
  input  wire logic        wr_lo_in,
  input  wire logic [7:0]  data_in,
  input  wire logic        clear_in,
  input  wire logic        take_in,
  output logic      [15:0] value_out,
  output logic             pending_out
);

  logic        hi_seen_r;
  logic        lo_seen_r;
  logic [15:0] buf_r;

  // Byte writes win over clear and take
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hi_seen_r <= 1'b0;
    end else if (wr_hi_in) begin
      hi_seen_r <= 1'b1;
    end else if (clear_in || take_in) begin
      hi_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lo_seen_r <= 1'b0;
    end else if (wr_lo_in) begin
      lo_seen_r <= 1'b1;
    end else if (clear_in || take_in) begin
      lo_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      buf_r <= 16'h0000;
    end else if (wr_hi_in) begin
      buf_r[15:8] <= data_in;
    end else if (wr_lo_in) begin
      buf_r[7:0] <= data_in;
    end
  end

  assign value_out   = buf_r;
  assign pending_out = hi_seen_r & lo_seen_r;

endmodule
`default_nettype wire

// ==== pcv_params.svh ====
`ifndef PCV_PARAMS_SVH
`define PCV_PARAMS_SVH

// Register offsets
`define PCV_ADDR_SC       3'h0
`define PCV_ADDR_CNTH     3'h1
`define PCV_ADDR_CNTL     3'h2
`define PCV_ADDR_MODH     3'h3
`define PCV_ADDR_MODL     3'h4
`define PCV_ADDR_CHSC     3'h5
`define PCV_ADDR_CVH      3'h6
`define PCV_ADDR_CVL      3'h7

// Field positions
`define PCV_SC_CLKS_LSB   3
`define PCV_SC_CLKS_MSB   4
`define PCV_SC_CPWM_BIT   5
`define PCV_CH_POL_BIT    0
`define PCV_CH_MODE_LSB   2
`define PCV_CH_MODE_MSB   3

// Reset values
`define PCV_SC_RST        8'h00
`define PCV_CHSC_RST      8'h00
`define PCV_MOD_RST       16'h0000
`define PCV_CV_RST        16'h0000
`define PCV_CNT_RST       16'h0000

// Counter limits
`define PCV_FREE_LOW      16'h0000
`define PCV_FREE_TOP      16'hffff
`define PCV_ONE           16'h0001
`define PCV_CLKS_OFF      2'h0

`endif

// ==== pcv_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module pcv_pin_model (
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        pwm_in,
  input  wire logic        oe_in,
  output logic             pin_out,
  output logic      [15:0] pulse_len_out,
  output logic      [15:0] pulse_cnt_out
);
  logic [15:0] run_r;

  // Pin pulled low while undriven
  assign pin_out = oe_in ? pwm_in : 1'b0;

  // Length of each finished high pulse
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      run_r <= 16'h0000;
      pulse_len_out <= 16'h0000;
      pulse_cnt_out <= 16'h0000;
    end else if (pin_out) begin
      run_r <= run_r + 16'h0001;
    end else if (run_r != 16'h0000) begin
      pulse_len_out <= run_r;
      pulse_cnt_out <= pulse_cnt_out + 16'h0001;
      run_r <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ==== pcv_pkg.sv ====
package pcv_pkg;

  typedef enum logic [1:0] {
    PCV_MODE_CAPTURE = 2'b00,
    PCV_MODE_COMPARE = 2'b01,
    PCV_MODE_EDGE    = 2'b10,
    PCV_MODE_EDGE2   = 2'b11
  } pcv_ch_mode_t;

  typedef enum logic {
    PCV_DIR_UP   = 1'b0,
    PCV_DIR_DOWN = 1'b1
  } pcv_dir_t;

endpackage

// ==== pwm_channel_value_update_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module pwm_channel_value_update_test;
  logic        clk;
  logic        rst;
  logic        wr_s;
  logic        rd_s;
  logic        dbg;
  logic [2:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        pwm;
  logic        oe;
  logic        pin;
  logic [15:0] plen;
  logic [15:0] pcnt;
  logic [15:0] top;
  logic [15:0] c;
  logic [15:0] h;
  logic [15:0] p;
  logic [7:0]  b0;
  logic [7:0]  b1;
  logic [31:0] seed;
  int          miscompares;
  int          check_count;

  pcv_channel #(.CNT_W(16)) uut (.ref_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
    .background_debug_state_in(dbg), .channel_pwm_out(pwm), .channel_oe_out(oe));
  pcv_pin_model pin_model (.ref_clk_in(clk), .sys_rst_in(rst), .pwm_in(pwm), .oe_in(oe),
    .pin_out(pin), .pulse_len_out(plen), .pulse_cnt_out(pcnt));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [15:0] edge_duty(input logic [15:0] v, input logic [15:0] t);
    return (v > t) ? t + 16'h0001 : v;
  endfunction
  function automatic logic [15:0] ctr_duty(input logic [15:0] v, input logic [15:0] t);
    return (v >= t) ? t << 1 : v << 1;
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic wr16(input logic [2:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 3'h1, v[7:0]);
  endtask
  task automatic duty(input int n);
    h = 16'h0000;
    repeat (n) begin
      @(negedge clk);
      h = h + {15'h0000, pin};
    end
  endtask
  task automatic wait_pulse(input int n);
    p = pcnt;
    for (int i = 0; i < n && pcnt == p; i++) @(negedge clk);
  endtask
  task automatic mod_check(input logic [15:0] exp);
    rd(3'h3, b1);
    rd(3'h4, b0);
    check("modulo", exp, {b1, b0});
  endtask
  task automatic complete_run;
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  initial begin
    miscompares = 0;
    check_count = 0;
    seed = 32'hdebd;
    rst = 1'b1;
    wr_s = 1'b0;
    rd_s = 1'b0;
    dbg = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], b0);
      check("reset value", 16'h0000, {8'h00, b0});
    end
    seed = xs(seed);
    top = {12'h000, seed[3:0]} + 16'h0010;
    wr16(3'h3, top);
    mod_check(top);
    wr(3'h5, 8'h09);
    wr(3'h0, 8'h08);
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      c = (i == 0) ? 16'h0000 : (i < 4) ? top + 16'(i) - 16'h2 : seed[15:0] % (top + 16'h2);
      wr16(3'h6, c);
      repeat (3 * (top + 1)) @(posedge clk);
      duty(top + 1);
      check("edge duty", edge_duty(c, top), h);
    end
    wr16(3'h6, 16'h0003);
    wr(3'h6, 8'h00);
    repeat (3 * (top + 1)) @(posedge clk);
    duty(top + 1);
    check("half pair", 16'h0003, h);
    wr(3'h0, 8'h08);
    wr(3'h7, 8'h05);
    repeat (3 * (top + 1)) @(posedge clk);
    duty(top + 1);
    check("pair cleared", 16'h0003, h);
    wr(3'h6, 8'h00);
    repeat (3 * (top + 1)) @(posedge clk);
    duty(top + 1);
    check("pair done", 16'h0005, h);
    wr(3'h5, 8'h08);
    repeat (top + 1) @(posedge clk);
    duty(top + 1);
    check("low polarity", top - 16'h0004, h);
    wr(3'h5, 8'h01);
    wr16(3'h6, 16'h0007);
    wr(3'h5, 8'h09);
    repeat (3 * (top + 1)) @(posedge clk);
    duty(top + 1);
    check("capture write", 16'h0005, h);
    wr(3'h5, 8'h05);
    wr16(3'h6, 16'h0009);
    rd(3'h6, b1);
    rd(3'h7, b0);
    check("compare load", 16'h0009, {b1, b0});
    check("pin enable", 16'h0000, {15'h0000, oe});
    wr(3'h5, 8'h09);
    wr(3'h3, 8'h00);
    wr(3'h0, 8'h08);
    wr(3'h4, top[7:0] + 8'h02);
    mod_check(top + 16'h0002);
    @(posedge clk);
    dbg <= 1'b1;
    wr(3'h3, 8'h00);
    wr(3'h0, 8'h08);
    wr(3'h4, 8'h02);
    dbg <= 1'b0;
    mod_check(top + 16'h0002);
    wr(3'h4, top[7:0]);
    wr(3'h3, 8'h00);
    mod_check(top);
    wr(3'h0, 8'h28);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      c = (i < 2) ? top - 16'(i) : (i == 2) ? 16'h0003 : seed[15:0] % top + 16'h0001;
      wr16(3'h6, c);
      repeat (6 * top) @(posedge clk);
      duty(2 * top);
      check("center duty", ctr_duty(c, top), h);
    end
    wr16(3'h6, 16'h0000);
    repeat (6 * top) @(posedge clk);
    c = 16'h0004;
    wr16(3'h6, c);
    wait_pulse(5 * top);
    check("rise pulse", 16'h0001, {15'h0000, (plen + 16'h1 >= c) && (plen <= c + 16'h1)});
    wait_pulse(3 * top);
    wr16(3'h6, 16'h0000);
    wait_pulse(3 * top);
    check("last pulse", 16'h0001, {15'h0000, (plen + 16'h1 >= c) && (plen <= c + 16'h1)});
    p = pcnt;
    repeat (4 * top) @(posedge clk);
    check("pulse count", p, pcnt);
    wr(3'h0, 8'h08);
    wr16(3'h3, 16'h0000);
    wr(3'h1, 8'h00);
    seed = xs(seed);
    c = seed[15:0] | 16'h0001;
    wr16(3'h6, c);
    repeat (65400) @(posedge clk);
    rd(3'h6, b1);
    rd(3'h7, b0);
    check("free hold", 16'h0000, {b1, b0});
    repeat (200) @(posedge clk);
    rd(3'h6, b1);
    rd(3'h7, b0);
    check("free load", c, {b1, b0});
    complete_run();
  end
endmodule
`default_nettype wire
